// file: core/fcs_core.sv
// Flash command launch, sequencing and status logic with AXI4-Lite register access
//
// Contract
// - Writing one to bit 7 launches command
// - Only burst commands buffer; clears on transfer
// - Buffer-empty reads 1 when buffer free; code holds it at 0 during the pump ramp and the blank scan
// - Complete sets when idle and buffer empty
// - Complete clears on launch; writes ignored
// - Protected target sets violation, drops command
// - Violation clears only on written one
// - Bad sequence sets access error, ignored
// - Program/erase before divider write is error
// - Stop during command sets access error
// - Access error clears on one only
// - Abort sets error; clear before next
// - Blank flag set only if all erased
// - Blank clears on launch; writes ignored
// - Pump on during program/erase command, off after (off in blank check)
// - Pump kept on between burst bytes
`timescale 1ns/1ns
module fcs_core
    import fcs_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    // AXI4-Lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // AXI4-Lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // System
    input  wire logic        stop_req,
    output logic             pump_on,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////
    // Storage and state
    logic [7:0]       mem [FCS_DEPTH];
    fcs_state_t       state;
    logic             cbef, ccf_busy, pviol, accerr, blank;
    logic             div_done;
    logic [7:0]       divider;
    logic [11:0]      addr_r, cnt;
    logic [7:0]       data_r, cmd_r;
    logic [3:0]       prot_blocks;
    logic             seq_addr, seq_cmd;
    logic             buf_full;
    logic [11:0]      buf_addr;
    logic [7:0]       buf_data;
    logic [11:0]      op_addr;
    logic [7:0]       op_data, op_cmd;
    logic             scan_ok;
    logic [3:0]       irq_stat, irq_mask;
    logic             aw_got, w_got;
    logic [7:0]       aw_addr_q;
    logic [31:0]      w_data_q;
    logic [3:0]       w_strb_q;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel: capture address and data in either order
    logic wr_fire;
    logic [7:0]  wa;
    logic [31:0] wd;
    logic        wb0;
    assign awready = !aw_got && !bvalid;
    assign wready  = !w_got && !bvalid;
    assign wr_fire = (aw_got || (awvalid && awready)) && (w_got || (wvalid && wready)) && !bvalid;
    assign wa  = aw_got ? aw_addr_q : awaddr;
    assign wd  = w_got ? w_data_q : wdata;
    assign wb0 = w_got ? w_strb_q[0] : wstrb[0];

    // Hold channel items until both are present, then answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
            bvalid <= 1'b0;
        end else begin
            if (wr_fire) begin
                aw_got <= 1'b0;
                w_got  <= 1'b0;
                bvalid <= 1'b1;
            end else begin
                if (awvalid && awready) begin
                    aw_got <= 1'b1;
                    aw_addr_q <= awaddr;
                end
                if (wvalid && wready) begin
                    w_got <= 1'b1;
                    w_data_q <= wdata;
                    w_strb_q <= wstrb;
                end
                if (bvalid && bready)
                    bvalid <= 1'b0;
            end
        end
    end

    // Unmapped addresses answer SLVERR
    logic wr_mapped;
    assign wr_mapped = (wa <= FCS_OFF_IRQ_MASK) && (wa[1:0] == 2'b00);
    always_ff @(posedge aclk) begin
        if (!aresetn)
            bresp <= 2'b00;
        else if (wr_fire)
            bresp <= wr_mapped ? 2'b00 : 2'b10;
    end

    // Byte-lane-0 write strobes per register
    // Control register is read-only, so it has no write strobe
    logic w_stat, w_div, w_addr, w_data, w_cmd, w_prot, w_istat, w_imask;
    assign w_stat  = wr_fire && wb0 && wa == FCS_OFF_STATUS;
    assign w_div   = wr_fire && wb0 && wa == FCS_OFF_DIVIDER;
    assign w_addr  = wr_fire && wb0 && wa == FCS_OFF_ADDR;
    assign w_data  = wr_fire && wb0 && wa == FCS_OFF_DATA;
    assign w_cmd   = wr_fire && wb0 && wa == FCS_OFF_COMMAND;
    assign w_prot  = wr_fire && wb0 && wa == FCS_OFF_PROTECT;
    assign w_istat = wr_fire && wb0 && wa == FCS_OFF_IRQ_STAT;
    assign w_imask = wr_fire && wb0 && wa == FCS_OFF_IRQ_MASK;

    ////////////////////////////////////////////////////////////////////////
    // Command decode at launch
    logic launch, busy, is_burst, is_pe, valid_cmd, prot_hit, seq_ok, acc_hit, start_op, buf_take;
    logic [2:0] tgt_blk;
    assign busy      = state != FCS_IDLE;
    assign launch    = w_stat && wd[FCS_BIT_CBEF] && cbef;
    assign is_burst  = cmd_r == FCS_CMD_BURST;
    assign valid_cmd = cmd_r == FCS_CMD_BLANK || cmd_r == FCS_CMD_PROGRAM || is_burst ||
                       cmd_r == FCS_CMD_ERASE || cmd_r == FCS_CMD_MASS;
    assign is_pe     = valid_cmd && cmd_r != FCS_CMD_BLANK;
    assign tgt_blk   = addr_r[11:9];
    // Top prot_blocks 512-byte blocks are protected; mass erase hits any
    assign prot_hit  = is_pe && prot_blocks != 4'h0 &&
                       (cmd_r == FCS_CMD_MASS || {1'b0, tgt_blk} >= 4'(8 - int'(prot_blocks)));
    assign seq_ok    = seq_cmd && valid_cmd && (seq_addr || cmd_r == FCS_CMD_BLANK || cmd_r == FCS_CMD_MASS);
    // Errors: bad sequence, no divider, uncleared error, busy with non-burst
    assign acc_hit   = launch && (!seq_ok || (is_pe && !div_done) || accerr || pviol ||
                                  (busy && !(is_burst && op_cmd == FCS_CMD_BURST)));
    assign start_op  = launch && !acc_hit && !prot_hit && !busy;
    assign buf_take  = launch && !acc_hit && !prot_hit && busy;

    ////////////////////////////////////////////////////////////////////////
    // Command-writing sequence tracking and staging registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_r <= 12'h000;
            data_r <= 8'h00;
            cmd_r  <= 8'h00;
            seq_addr <= 1'b0;
            seq_cmd  <= 1'b0;
        end else begin
            if (launch) begin
                seq_addr <= 1'b0;
                seq_cmd  <= 1'b0;
            end else begin
                if (w_addr) begin
                    addr_r <= wd[11:0];
                    seq_addr <= 1'b1;
                end
                if (w_data)
                    data_r <= wd[7:0];
                if (w_cmd) begin
                    cmd_r <= wd[7:0];
                    seq_cmd <= 1'b1;
                end
            end
        end
    end

    // Divider and protection configuration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            divider <= 8'h00;
            div_done <= 1'b0;
            prot_blocks <= 4'h0;
        end else begin
            if (w_div) begin
                divider <= wd[7:0];
                div_done <= 1'b1;
            end
            if (w_prot && wd[3:0] <= 4'h8)
                prot_blocks <= wd[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command buffer for one burst byte
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buf_full <= 1'b0;
            buf_addr <= 12'h000;
            buf_data <= 8'h00;
        end else if (state == FCS_NEXT || stop_req) begin
            buf_full <= 1'b0;
        end else if (buf_take) begin
            buf_full <= 1'b1;
            buf_addr <= addr_r;
            buf_data <= data_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: pump ramp, execute, blank scan, burst handoff
    logic done_op;
    assign done_op = (state == FCS_EXEC || state == FCS_SCAN) && cnt == 12'h000 && !stop_req;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state   <= FCS_IDLE;
            cnt     <= 12'h000;
            op_addr <= 12'h000;
            op_data <= 8'h00;
            op_cmd  <= 8'h00;
            scan_ok <= 1'b0;
        end else if (stop_req && busy) begin
            state <= FCS_IDLE;
        end else begin
            case (state)
                FCS_IDLE: if (start_op) begin
                    op_addr <= addr_r;
                    op_data <= data_r;
                    op_cmd  <= cmd_r;
                    scan_ok <= 1'b1;
                    if (cmd_r == FCS_CMD_BLANK) begin
                        state <= FCS_SCAN;
                        cnt   <= 12'(FCS_DEPTH - 1);
                        op_addr <= 12'h000;
                    end else begin
                        state <= FCS_PUMP;
                        cnt   <= FCS_PUMP_CYC;
                    end
                end
                FCS_PUMP: if (cnt == 12'h000) begin
                    state <= FCS_EXEC;
                    cnt   <= (op_cmd == FCS_CMD_ERASE || op_cmd == FCS_CMD_MASS) ? FCS_ERASE_CYC :
                             (op_cmd == FCS_CMD_BURST) ? FCS_BURST_CYC : FCS_PROG_CYC;
                end else
                    cnt <= cnt - 12'h001;
                FCS_EXEC: if (cnt == 12'h000)
                    state <= (op_cmd == FCS_CMD_BURST && buf_full) ? FCS_NEXT : FCS_IDLE;
                else
                    cnt <= cnt - 12'h001;
                FCS_SCAN: begin
                    if (mem[op_addr] != FCS_ERASED)
                        scan_ok <= 1'b0;
                    op_addr <= op_addr + 12'h001;
                    if (cnt == 12'h000)
                        state <= FCS_IDLE;
                    else
                        cnt <= cnt - 12'h001;
                end
                FCS_NEXT: begin
                    // Pump stays up; next byte skips the ramp
                    op_addr <= buf_addr;
                    op_data <= buf_data;
                    cnt     <= FCS_BURST_CYC;
                    state   <= FCS_EXEC;
                end
                default: state <= FCS_IDLE;
            endcase
        end
    end

    // Array update at the end of a program or erase
    always_ff @(posedge aclk) begin
        if (done_op && state == FCS_EXEC) begin
            if (op_cmd == FCS_CMD_MASS) begin
                for (int i = 0; i < FCS_DEPTH; i++)
                    mem[i] <= FCS_ERASED;
            end else if (op_cmd == FCS_CMD_ERASE) begin
                for (int i = 0; i < 512; i++)
                    mem[{op_addr[11:9], 9'(i)}] <= FCS_ERASED;
            end else
                mem[op_addr] <= mem[op_addr] & op_data;
        end
    end

    // Charge pump enable
    assign pump_on = state == FCS_PUMP || state == FCS_EXEC || state == FCS_NEXT;

    ////////////////////////////////////////////////////////////////////////
    // Status flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cbef <= 1'b1;
            ccf_busy <= 1'b0;
        end else begin
            if (launch && !acc_hit && !prot_hit)
                cbef <= 1'b0;
            else if (!buf_full && !buf_take && (state == FCS_IDLE || state == FCS_EXEC))
                cbef <= 1'b1;
            ccf_busy <= busy || start_op;
        end
    end

    // Violation, access error, blank; hardware set wins over software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pviol  <= 1'b0;
            accerr <= 1'b0;
            blank  <= 1'b0;
        end else begin
            if (launch && prot_hit && !acc_hit)
                pviol <= 1'b1;
            else if (w_stat && wd[FCS_BIT_PVIOL])
                pviol <= 1'b0;
            if (acc_hit || (stop_req && busy))
                accerr <= 1'b1;
            else if (w_stat && wd[FCS_BIT_ACCER])
                accerr <= 1'b0;
            if (start_op)
                blank <= 1'b0;
            else if (state == FCS_SCAN && cnt == 12'h000 && !stop_req)
                blank <= scan_ok && mem[op_addr] == FCS_ERASED;
        end
    end

    logic ccf;
    logic [7:0] status;
    assign ccf = cbef && !ccf_busy && !busy;
    assign status = {cbef, ccf, pviol, accerr, 1'b0, blank, 2'b00};

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: sticky events, write one to clear, set wins
    logic [3:0] ev;
    assign ev = {cbef && busy && !buf_full, launch && acc_hit, launch && prot_hit && !acc_hit, done_op};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= 4'h0;
            irq_mask <= 4'h0;
        end else begin
            irq_stat <= ev | (irq_stat & ~((w_istat) ? wd[3:0] : 4'h0));
            if (w_imask)
                irq_mask <= wd[3:0] & FCS_IRQ_MASK_W;
        end
    end
    assign irq = |(irq_stat & irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    assign arready = !rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= 2'b00;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp  <= 2'b00;
            case (araddr)
                FCS_OFF_STATUS:   rdata <= {24'h000000, status};
                FCS_OFF_DIVIDER:  rdata <= {24'h000000, divider};
                FCS_OFF_ADDR:     rdata <= {20'h00000, addr_r};
                FCS_OFF_DATA:     rdata <= {24'h000000, data_r};
                FCS_OFF_COMMAND:  rdata <= {24'h000000, cmd_r};
                FCS_OFF_PROTECT:  rdata <= {28'h0000000, prot_blocks};
                FCS_OFF_CONTROL:  rdata <= {31'h00000000, div_done};
                FCS_OFF_IRQ_STAT: rdata <= {28'h0000000, irq_stat};
                FCS_OFF_IRQ_MASK: rdata <= {28'h0000000, irq_mask};
                default: begin
                    rdata <= 32'h00000000;
                    rresp <= 2'b10;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    launch_clears_a: assert property (@(posedge aclk) disable iff (!aresetn)
        start_op |=> !cbef) else $error("buffer-empty not cleared at launch");
    complete_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
        start_op |=> !ccf) else $error("complete flag high after launch");
    complete_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == FCS_IDLE && !buf_full && !launch) |=> ccf) else $error("complete flag low when idle");
    pviol_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (launch && prot_hit && !acc_hit && !busy) |=> pviol && state == FCS_IDLE)
        else $error("protected command not dropped");
    accerr_div_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (launch && is_pe && !div_done && !busy) |=> accerr && !busy) else $error("no error without divider");
    stop_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (stop_req && busy) |=> accerr && state == FCS_IDLE) else $error("stop did not abort");
    accerr_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (accerr && !(w_stat && wd[FCS_BIT_ACCER])) |=> accerr) else $error("access error lost");
    // A stop request legally cuts the pump short, so it ends the check
    pump_prog_a: assert property (@(posedge aclk) disable iff (!aresetn || stop_req)
        (start_op && cmd_r == FCS_CMD_PROGRAM) |=> pump_on [*8]) else $error("pump dropped early");
    burst_pump_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == FCS_NEXT) |-> pump_on ##1 (state == FCS_EXEC && pump_on)) else $error("pump gap in burst");
    reserved_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (arvalid && arready && araddr == FCS_OFF_STATUS) |=> rdata[3] == 1'b0 && rdata[1:0] == 2'b00)
        else $error("reserved bits set");

endmodule : fcs_core

// file: core/fcs_pkg.sv
// Package with register map, field positions and timing for the flash command/status block
package fcs_pkg;

    // Register byte offsets
    localparam logic [7:0] FCS_OFF_STATUS    = 8'h00;
    localparam logic [7:0] FCS_OFF_DIVIDER   = 8'h04;
    localparam logic [7:0] FCS_OFF_ADDR      = 8'h08;
    localparam logic [7:0] FCS_OFF_DATA      = 8'h0C;
    localparam logic [7:0] FCS_OFF_COMMAND   = 8'h10;
    localparam logic [7:0] FCS_OFF_PROTECT   = 8'h14;
    localparam logic [7:0] FCS_OFF_CONTROL   = 8'h18;
    localparam logic [7:0] FCS_OFF_IRQ_STAT  = 8'h1C;
    localparam logic [7:0] FCS_OFF_IRQ_MASK  = 8'h20;

    // Status register bit positions
    localparam int FCS_BIT_CBEF  = 7;
    localparam int FCS_BIT_CCF   = 6;
    localparam int FCS_BIT_PVIOL = 5;
    localparam int FCS_BIT_ACCER = 4;
    localparam int FCS_BIT_BLANK = 2;

    // Interrupt status bit positions
    localparam int FCS_IRQ_DONE  = 0;
    localparam int FCS_IRQ_PVIOL = 1;
    localparam int FCS_IRQ_ACCER = 2;
    localparam int FCS_IRQ_BEMPT = 3;
    localparam logic [3:0] FCS_IRQ_MASK_W = 4'hF;

    // Command codes
    localparam logic [7:0] FCS_CMD_BLANK   = 8'h05;
    localparam logic [7:0] FCS_CMD_PROGRAM = 8'h20;
    localparam logic [7:0] FCS_CMD_BURST   = 8'h25;
    localparam logic [7:0] FCS_CMD_ERASE   = 8'h40;
    localparam logic [7:0] FCS_CMD_MASS    = 8'h41;

    // Array geometry: 4096 bytes, protection boundary in 512-byte blocks
    localparam int FCS_AW = 12;
    localparam int FCS_DEPTH = 4096;
    localparam logic [7:0] FCS_ERASED = 8'hFF;

    // Timing: operation times in ns and derived cycle counts at 25 MHz
    localparam int FCS_CLK_NS      = 40;
    localparam int FCS_PROG_NS     = 800;
    localparam int FCS_BURST_NS    = 400;
    localparam int FCS_ERASE_NS    = 4000;
    localparam int FCS_PUMP_NS     = 200;
    localparam logic [11:0] FCS_PROG_CYC  = 12'((FCS_PROG_NS  + FCS_CLK_NS - 1) / FCS_CLK_NS);
    localparam logic [11:0] FCS_BURST_CYC = 12'((FCS_BURST_NS + FCS_CLK_NS - 1) / FCS_CLK_NS);
    localparam logic [11:0] FCS_ERASE_CYC = 12'((FCS_ERASE_NS + FCS_CLK_NS - 1) / FCS_CLK_NS);
    localparam logic [11:0] FCS_PUMP_CYC  = 12'((FCS_PUMP_NS  + FCS_CLK_NS - 1) / FCS_CLK_NS);

    // Reset values
    localparam logic [7:0] FCS_STATUS_RST = 8'hC0;

    // Sequencer states
    typedef enum logic [2:0] {
        FCS_IDLE,
        FCS_PUMP,
        FCS_EXEC,
        FCS_SCAN,
        FCS_NEXT
    } fcs_state_t;

endpackage : fcs_pkg

// file: tb/fcs_core_tb_top.sv
// Self-checking testbench for the flash command and status block
`timescale 1ns/1ns
module fcs_core_tb_top
    import fcs_pkg::*;
;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, stop_req;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, last_bresp, last_rresp;
    logic        awready, wready, bvalid, arready, rvalid, pump_on, irq, pump_q;
    int          n_fail = 0, n_tests = 0, n_falls = 0;

    fcs_core i_fcs_core (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .stop_req(stop_req), .pump_on(pump_on), .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    // Clock generation
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // Count charge pump switch-offs
    always @(posedge aclk) begin
        pump_q <= pump_on;
        if (pump_q === 1'b1 && pump_on === 1'b0) n_falls <= n_falls + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare and report
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up

    // Bus write: ready sampled at the falling edge, taken at the next rising edge
    // Response ready stays high between transfers so it is never driven twice in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ah, wh, bh;
        bh = 1'b0;
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (int k = 0; k < 50 && !bh; k++) begin
            @(negedge aclk);
            ah = awvalid && awready; wh = wvalid && wready; bh = bready && bvalid; last_bresp = bresp;
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
        end
        if (!bh) begin n_fail++; wrap_up(); end
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic ah, rh;
        rh = 1'b0;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (int k = 0; k < 50 && !rh; k++) begin
            @(negedge aclk);
            ah = arvalid && arready; rh = rready && rvalid; d = rdata;
            last_rresp = rresp;
            @(posedge aclk);
            if (ah) arvalid <= 1'b0;
        end
        if (!rh) begin n_fail++; wrap_up(); end
    endtask : rd

    task automatic st(input logic [31:0] e);
        logic [31:0] v;
        rd(FCS_OFF_STATUS, v);
        check("status", v, e);
    endtask : st

    task automatic launch(input logic [7:0] c, input logic [11:0] a);
        wr(FCS_OFF_ADDR, {20'h00000, a});
        wr(FCS_OFF_DATA, 32'h00000000);
        wr(FCS_OFF_COMMAND, {24'h000000, c});
        wr(FCS_OFF_STATUS, 32'h00000080);
    endtask : launch

    // Poll until the complete flag is back, bounded
    task automatic wait_done;
        logic [31:0] v;
        v = '0;
        for (int k = 0; k < 3000 && v[6] !== 1'b1; k++) rd(FCS_OFF_STATUS, v);
        if (v[6] !== 1'b1) begin n_fail++; wrap_up(); end
    endtask : wait_done

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset_and_divider;
        logic [31:0] v;
        st(32'h000000C0);
        check("pump", pump_on, 1'b0);
        wr(8'h30, 32'h00000001);
        check("bresp", last_bresp, 2'b10);
        rd(8'h30, v);
        check("rresp", {30'h0, last_rresp}, 32'h2);
        check("rdata unmapped", v, 32'h0);
        launch(FCS_CMD_PROGRAM, 12'h000);
        st(32'h000000D0);
        wr(FCS_OFF_STATUS, 32'h00000000);
        st(32'h000000D0);
        wr(FCS_OFF_STATUS, 32'h00000010);
        st(32'h000000C0);
    endtask : t_reset_and_divider

    task automatic t_blank_program_irq;
        logic [31:0] v;
        int f;
        wr(FCS_OFF_DIVIDER, 32'h00000001);
        // Array contents are unknown at start, so erase it all before the blank check
        launch(FCS_CMD_MASS, 12'h000);
        wait_done();
        launch(FCS_CMD_BLANK, 12'h000);
        wait_done();
        st(32'h000000C4);
        wr(FCS_OFF_STATUS, 32'h00000004);
        st(32'h000000C4);
        wr(FCS_OFF_IRQ_STAT, 32'h0000000F);
        wr(FCS_OFF_IRQ_MASK, 32'h00000001);
        f = n_falls;
        launch(FCS_CMD_PROGRAM, 12'h000);
        rd(FCS_OFF_STATUS, v);
        check("complete", {31'h0, v[6]}, 32'h0);
        wait_done();
        st(32'h000000C0);
        check("pump offs", 32'(n_falls - f), 32'h1);
        @(negedge aclk);
        check("irq on", irq, 1'b1);
        wr(FCS_OFF_IRQ_MASK, 32'h00000000);
        @(negedge aclk);
        check("irq masked", irq, 1'b0);
        wr(FCS_OFF_IRQ_STAT, 32'h0000000F);
        wr(FCS_OFF_IRQ_MASK, 32'h00000001);
        @(negedge aclk);
        check("irq cleared", irq, 1'b0);
        launch(FCS_CMD_BLANK, 12'h000);
        wait_done();
        st(32'h000000C0);
    endtask : t_blank_program_irq

    task automatic t_errors;
        launch(8'h77, 12'h000);
        st(32'h000000D0);
        wr(FCS_OFF_STATUS, 32'h00000010);
        wr(FCS_OFF_PROTECT, 32'h00000008);
        launch(FCS_CMD_PROGRAM, 12'h000);
        st(32'h000000E0);
        wr(FCS_OFF_STATUS, 32'h00000010);
        st(32'h000000E0);
        wr(FCS_OFF_STATUS, 32'h00000020);
        st(32'h000000C0);
        wr(FCS_OFF_PROTECT, 32'h00000000);
        wr(FCS_OFF_STATUS, 32'h0000004F);
        st(32'h000000C0);
    endtask : t_errors

    task automatic t_stop_abort;
        launch(FCS_CMD_PROGRAM, 12'h004);
        repeat (3) @(posedge aclk);
        stop_req <= 1'b1;
        repeat (3) @(posedge aclk);
        stop_req <= 1'b0;
        wait_done();
        st(32'h000000D0);
        launch(FCS_CMD_PROGRAM, 12'h004);
        @(negedge aclk);
        check("pump", pump_on, 1'b0);
        st(32'h000000D0);
        wr(FCS_OFF_STATUS, 32'h00000010);
    endtask : t_stop_abort

    task automatic t_burst;
        logic [31:0] v;
        int f;
        f = n_falls;
        launch(FCS_CMD_BURST, 12'h001);
        wr(FCS_OFF_ADDR, 32'h00000002);
        wr(FCS_OFF_DATA, 32'h00000000);
        wr(FCS_OFF_COMMAND, {24'h000000, FCS_CMD_BURST});
        rd(FCS_OFF_STATUS, v);
        check("buffer free", {31'h0, v[7]}, 32'h1);
        wr(FCS_OFF_STATUS, 32'h00000080);
        wait_done();
        st(32'h000000C0);
        check("pump offs", 32'(n_falls - f), 32'h1);
    endtask : t_burst

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        stop_req = 1'b0; awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'hF;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset_and_divider();
        t_blank_program_irq();
        t_errors();
        t_stop_abort();
        t_burst();
        wrap_up();
    end
endmodule : fcs_core_tb_top
